// [rtl/aspm_pkg.sv]
package aspm_pkg;

  // ----------------------------------------------------------------
  // Frame timing, counted in serial clock falling edges
  // ----------------------------------------------------------------
  localparam logic [4:0] ASPM_PD_WIN_LO   = 5'h02;  // Earliest edge count that opens power-down
  localparam logic [4:0] ASPM_PD_WIN_HI   = 5'h0A;  // Edge count that closes power-down window
  localparam logic [4:0] ASPM_TRACK_EDGE  = 5'h0D;  // Falling edges before return to track
  localparam logic [4:0] ASPM_FRAME_EDGES = 5'h10;  // Falling edges in a full frame
  localparam logic [4:0] ASPM_FIRST_DATA  = 5'h03;  // Edge count shifting out the last leading zero
  localparam int         ASPM_RESULT_W    = 12;

  // ----------------------------------------------------------------
  // Wake-up delay, checked by the master only
  // ----------------------------------------------------------------
  localparam int ASPM_FULL_WAKE_DELAY_US = 650;
  localparam int ASPM_CLK_MHZ            = 200;
  localparam int ASPM_FULL_WAKE_CYCLES   = ASPM_FULL_WAKE_DELAY_US * ASPM_CLK_MHZ;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASPM_NORMAL  = 2'b00,
    ASPM_PARTIAL = 2'b01,
    ASPM_FULL    = 2'b11
  } aspm_mode_e;

  localparam aspm_mode_e ASPM_MODE_RESET = ASPM_NORMAL;

endpackage

// [rtl/aspm_sync_if.sv]
// Synchronised pin events passed from the sampler to the frame logic
interface aspm_sync_if;
  logic sel_low;     // Filtered level of frame select, high while selected
  logic sel_fall;    // One-cycle pulse on frame select falling
  logic sel_rise;    // One-cycle pulse on frame select rising
  logic sclk_fall;   // One-cycle pulse on serial clock falling
  logic sclk_rise;   // One-cycle pulse on serial clock rising

  modport src (output sel_low, output sel_fall, output sel_rise,
               output sclk_fall, output sclk_rise);
  modport dst (input sel_low, input sel_fall, input sel_rise,
               input sclk_fall, input sclk_rise);
endinterface

// [rtl/aspm_pin_sync.sv]
module aspm_pin_sync (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic sel_n_in,
  input  wire logic sclk_in,
  aspm_sync_if.src  ev
);

  logic [2:0] sel_pipe;
  logic [2:0] sclk_pipe;
  logic       sel_state;
  logic       sclk_state;

  // ----------------------------------------------------------------
  // Three-stage samplers; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_pipe  <= 3'b111;
      sclk_pipe <= 3'b111;                 // Idle high, so no false edge follows reset
    end else begin
      sel_pipe  <= {sel_pipe[1:0], sel_n_in};
      sclk_pipe <= {sclk_pipe[1:0], sclk_in};
    end
  end

  // Accepted levels; stage one is never read here
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_state  <= 1'b1;
      sclk_state <= 1'b1;
    end else begin
      if (sel_pipe[1] == sel_pipe[2]) begin
        sel_state <= sel_pipe[2];
      end
      if (sclk_pipe[1] == sclk_pipe[2]) begin
        sclk_state <= sclk_pipe[2];
      end
    end
  end

  // Edge pulses derived from the accepted levels
  always_comb begin
    ev.sel_low   = ~sel_state;
    ev.sel_fall  = sel_state & (sel_pipe[1] == sel_pipe[2]) & ~sel_pipe[2];
    ev.sel_rise  = ~sel_state & (sel_pipe[1] == sel_pipe[2]) & sel_pipe[2];
    ev.sclk_fall = sclk_state & (sclk_pipe[1] == sclk_pipe[2]) & ~sclk_pipe[2];
    ev.sclk_rise = ~sclk_state & (sclk_pipe[1] == sclk_pipe[2]) & sclk_pipe[2];
  end

endmodule

// [rtl/aspm_ctrl.sv]
module aspm_ctrl
  import aspm_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     sel_n_in,
  input  wire logic                     sclk_in,
  input  wire logic [ASPM_RESULT_W-1:0] result_in,
  output logic                          serial_result_out,
  output logic                          serial_result_oe_out,
  output logic                          track_out,
  output logic                          convert_out,
  output logic [1:0]                    power_mode_out,
  output logic                          powered_out
);

  aspm_sync_if ev ();

  logic [4:0]               edge_cnt;
  logic [15:0]              shift_reg;
  logic                     in_frame;
  logic                     track_pend;
  aspm_mode_e               mode;
  aspm_mode_e               frame_mode;
  logic                     wake_frame;

  // Edge count bucket test, used by the mode decision on select rise
  function automatic logic in_window(input logic [4:0] cnt, input logic [4:0] lo,
                                     input logic [4:0] hi);
    in_window = (cnt >= lo) && (cnt < hi);
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  aspm_pin_sync u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .sel_n_in (sel_n_in),
    .sclk_in  (sclk_in),
    .ev       (ev.src)
  );

  // ----------------------------------------------------------------
  // Frame edge counter
  // ----------------------------------------------------------------
  // The serial clock alone paces conversion and shifting
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_cnt <= 5'h00;
      in_frame <= 1'b0;
    end else if (ev.sel_fall) begin
      edge_cnt <= 5'h00;
      in_frame <= 1'b1;
    end else if (ev.sel_rise) begin
      in_frame <= 1'b0;
    end else if (in_frame && ev.sel_low && ev.sclk_fall) begin
      edge_cnt <= edge_cnt + 5'h01;
      if (edge_cnt + 5'h01 == ASPM_FRAME_EDGES) begin
        in_frame <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode decisions on select fall and rise
  // ----------------------------------------------------------------
  // The mode at frame start is kept so a wake frame can be judged
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode       <= ASPM_MODE_RESET;
      frame_mode <= ASPM_MODE_RESET;
      wake_frame <= 1'b0;
    end else if (ev.sel_fall) begin
      frame_mode <= mode;
      wake_frame <= (mode != ASPM_NORMAL);
      if (mode != ASPM_NORMAL) begin
        mode <= ASPM_NORMAL;                             // waking starts here
      end
    end else if (ev.sel_rise && in_frame) begin
      if (in_window(edge_cnt, ASPM_PD_WIN_LO, ASPM_PD_WIN_HI)) begin
        // Window rise steps one level deeper; full stays full
        mode <= (frame_mode == ASPM_NORMAL) ? ASPM_PARTIAL : ASPM_FULL;
      end else if (edge_cnt < ASPM_PD_WIN_LO) begin
        // Glitch filter: early rise restores the mode held before
        mode <= frame_mode;
      end else begin
        mode <= ASPM_NORMAL;
      end
    end else if (ev.sclk_fall && in_frame && edge_cnt + 5'h01 == ASPM_PD_WIN_HI) begin
      wake_frame <= 1'b0;                                // Wake committed
    end
  end

  // ----------------------------------------------------------------
  // Track-and-hold control
  // ----------------------------------------------------------------
  // Tracks from reset, so no dummy frame is needed to acquire
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      track_out  <= 1'b1;
      track_pend <= 1'b0;
      convert_out <= 1'b0;
    end else if (ev.sel_fall) begin
      track_out   <= (mode != ASPM_NORMAL) ? 1'b1 : 1'b0;
      convert_out <= (mode == ASPM_NORMAL);
      track_pend  <= 1'b0;
    end else if (ev.sel_rise) begin
      track_out   <= 1'b1;
      convert_out <= 1'b0;
      track_pend  <= 1'b0;
    end else if (ev.sclk_fall && in_frame && edge_cnt + 5'h01 == ASPM_TRACK_EDGE) begin
      track_pend <= 1'b1;
    end else if (ev.sclk_rise && track_pend) begin
      track_out   <= 1'b1;
      track_pend  <= 1'b0;
    end else if (ev.sclk_fall && in_frame && edge_cnt + 5'h01 == ASPM_FRAME_EDGES) begin
      convert_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial output shifter
  // ----------------------------------------------------------------
  // Four leading zeros then twelve result bits, MSB first
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_reg            <= 16'h0000;
      serial_result_out    <= 1'b0;
      serial_result_oe_out <= 1'b0;
    end else if (ev.sel_fall) begin
      shift_reg            <= {4'h0, result_in};
      serial_result_out    <= 1'b0;                      // first zero
      serial_result_oe_out <= 1'b1;
    end else if (!ev.sel_low || ev.sel_rise) begin
      serial_result_oe_out <= 1'b0;
    end else if (in_frame && ev.sclk_fall) begin
      if (edge_cnt + 5'h01 == ASPM_FRAME_EDGES) begin
        serial_result_oe_out <= 1'b0;
      end else begin
        // Edge n presents bit n+1; edge 15 presents the result LSB
        shift_reg         <= {shift_reg[14:0], 1'b0};
        serial_result_out <= shift_reg[15 - 1 - 0];
      end
    end
  end

  // Mode and power reports
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_mode_out <= 2'b00;
      powered_out    <= 1'b1;
    end else begin
      power_mode_out <= mode;
      powered_out    <= (mode == ASPM_NORMAL) && !wake_frame;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_WIN_TO_PARTIAL: assert property (
    ev.sel_rise && in_frame && frame_mode == ASPM_NORMAL && edge_cnt >= ASPM_PD_WIN_LO
      && edge_cnt < ASPM_PD_WIN_HI |=> mode == ASPM_PARTIAL)
    else $error("window rise in normal mode did not enter partial");

  AST_WIN_TO_FULL: assert property (
    ev.sel_rise && in_frame && frame_mode == ASPM_PARTIAL && edge_cnt >= ASPM_PD_WIN_LO
      && edge_cnt < ASPM_PD_WIN_HI |=> mode == ASPM_FULL)
    else $error("window rise in partial mode did not enter full");

  AST_EARLY_KEEP: assert property (
    ev.sel_rise && in_frame && edge_cnt < ASPM_PD_WIN_LO |=> mode == $past(frame_mode))
    else $error("early select rise changed the mode");

  AST_LATE_POWERED: assert property (
    ev.sel_rise && in_frame && edge_cnt >= ASPM_PD_WIN_HI |=> mode == ASPM_NORMAL
      ##1 !serial_result_oe_out)
    else $error("late select rise did not keep power or release line");

  AST_FALL_DRIVES: assert property (
    ev.sel_fall |=> serial_result_oe_out && !serial_result_out)
    else $error("select fall did not drive first zero");

  AST_RELEASE_HIGH: assert property (
    !ev.sel_low && !$past(ev.sel_low) |-> !serial_result_oe_out)
    else $error("output driven while select high");

  AST_END_RELEASE: assert property (
    ev.sclk_fall && in_frame && ev.sel_low && !ev.sel_rise
      && edge_cnt + 5'h01 == ASPM_FRAME_EDGES
      |=> !serial_result_oe_out && !in_frame)
    else $error("line not released at sixteenth edge");

  AST_TRACK_BACK: assert property (
    track_pend && ev.sclk_rise && !ev.sel_fall && !ev.sel_rise |=> track_out)
    else $error("track not resumed after thirteenth edge");

  COV_FULL_FRAME: cover property (ev.sclk_fall && in_frame && edge_cnt == 5'h0F);
  COV_PARTIAL:    cover property (mode == ASPM_NORMAL ##1 mode == ASPM_PARTIAL);
  COV_FULL:       cover property (mode == ASPM_PARTIAL ##1 mode == ASPM_FULL);
  COV_WAKE:       cover property (mode == ASPM_FULL ##1 mode == ASPM_NORMAL);

endmodule

// [dv/aspm_master_model.sv]
// ----------------------------------------------------------------
// Serial master: drives select and a gated serial clock
// ----------------------------------------------------------------
module aspm_master_model #(
  parameter int HALF_NS      = 24,
  parameter int QUIET_NS     = 200,
  parameter int FULL_WAKE_NS = 2000
) (
  input  wire logic serial_result_in,
  input  wire logic serial_result_oe_in,
  input  wire logic track_in,
  input  wire logic convert_in,
  output logic      sel_n_out,
  output logic      sclk_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic seen_data[$];
  logic seen_oe[$];
  logic seen_track[$];
  logic seen_conv[$];
  logic seen_rise[$];

  // Clock idles high and stands still outside frames
  initial begin
    sel_n_out = 1'b1;
    sclk_out  = 1'b1;
  end

  // One frame of n falling edges; the odd offset keeps pin edges off mclk edges
  task automatic frame(input int n);
    seen_data.delete();
    seen_oe.delete();
    seen_track.delete();
    seen_conv.delete();
    seen_rise.delete();
    #1.2;
    sel_n_out = 1'b0;  // Select fall starts sampling and conversion in normal mode, a wake otherwise
    #(2 * HALF_NS);
    for (int k = 1; k <= n; k++) begin
      // Bit presented before fall k is taken at fall k
      seen_data.push_back(serial_result_in);
      seen_oe.push_back(serial_result_oe_in);
      seen_track.push_back(track_in);
      seen_conv.push_back(convert_in);
      sclk_out = 1'b0;  // Serial clock doubles as conversion clock
      #(HALF_NS);
      seen_rise.push_back(serial_result_in);  // Slow master taking data on rise
      sclk_out = 1'b1;
      #(HALF_NS);
    end
    sel_n_out = 1'b1;  // Remaining clocks are never sent after a short frame
    #(QUIET_NS);       // Quiet interval before the next select fall
  endtask
endmodule

// [dv/tb.sv]
module tb;
  import aspm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic                     mclk_in;
  logic                     rst_n_in;
  logic [ASPM_RESULT_W-1:0] result_in;
  logic                     sel_n;
  logic                     sclk;
  logic                     ser_data;
  logic                     ser_data_oe;
  logic                     track;
  logic                     convert;
  logic [1:0]               power_mode;
  logic                     powered;
  int                       failures;
  int                       checks_done;
  int                       seed;
  int                       mode;     // Model mode: 0 normal, 1 partial, 2 full
  logic [1:0]               mode_enc [3] = '{2'b00, 2'b01, 2'b11};
  int                       plan [$] = '{16, 16, 12, 1, 0, 9, 1, 2, 1, 16, 16, 5, 10, 16};

  aspm_ctrl i_dut (
    .mclk_in              (mclk_in),
    .rst_n_in             (rst_n_in),
    .sel_n_in             (sel_n),
    .sclk_in              (sclk),
    .result_in            (result_in),
    .serial_result_out    (ser_data),
    .serial_result_oe_out (ser_data_oe),
    .track_out            (track),
    .convert_out          (convert),
    .power_mode_out       (power_mode),
    .powered_out          (powered)
  );

  aspm_master_model i_master (
    // A released line reads as the inverse, so stale data cannot pass
    .serial_result_in    (ser_data_oe ? ser_data : ~ser_data),
    .serial_result_oe_in (ser_data_oe),
    .track_in            (track),
    .convert_in          (convert),
    .sel_n_out           (sel_n),
    .sclk_out            (sclk)
  );

  // 200 MHz system clock
  initial mclk_in = 1'b0;
  always #2.5 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Mode, power and line state after the pins have settled
  task automatic check_idle();
    check("oe_idle", 12'(ser_data_oe), 12'h000);
    check("mode", 12'(power_mode), 12'(mode_enc[mode]));
    check("powered", 12'(powered), 12'(mode == 0));
  endtask

  // ----------------------------------------------------------------
  // One frame against the model; data only counts if it began powered
  // ----------------------------------------------------------------
  task automatic run(input int n);
    int         start;
    logic [15:0] word;
    start = mode;
    @(posedge mclk_in);
    result_in <= ASPM_RESULT_W'($random(seed));
    @(posedge mclk_in);
    word = {4'h0, result_in};  // Four leading zeros, then MSB first
    i_master.frame(n);
    for (int k = 0; k < n; k++) begin
      if (start == 0) begin
        check("data", 12'(i_master.seen_data[k]), 12'(word[15-k]));
        check("oe", 12'(i_master.seen_oe[k]), 12'h001);
        check("convert", 12'(i_master.seen_conv[k]), 12'h001);
        if (k != 13) check("track", 12'(i_master.seen_track[k]), 12'(k > 13));
        if (k < 15) check("rise_data", 12'(i_master.seen_rise[k]), 12'(word[14-k]));
      end else begin
        check("wake_track", 12'(i_master.seen_track[k]), 12'h001);
        check("wake_conv", 12'(i_master.seen_conv[k]), 12'h000);
      end
    end
    if (n >= 10) mode = 0;           // Long frame keeps or restores power
    else if (n >= 2 && mode < 2) mode = mode + 1;  // Window rise steps deeper
    check_idle();
    if (start == 2 && n >= 10) #(i_master.FULL_WAKE_NS);  // Wait FULL_WAKE_NS, well short of the 650 us full_wake_delay
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    mode = 0;
    repeat (2) @(posedge mclk_in);
    #1;
    check("track_por", 12'(track), 12'h001);
    check_idle();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    rst_n_in    = 1'b0;
    result_in   = '0;
    failures    = 0;
    checks_done = 0;
    seed        = 44325;
    do_reset();
    foreach (plan[i]) run(plan[i]);
    // Random frame lengths; a window rise from full is left alone
    repeat (14) begin
      n = $unsigned($random(seed)) % 17;
      if (mode == 2 && n >= 2) n = 16;
      run(n);
    end
    // Second reset, then power-down through partial to full and a wake from full
    do_reset();
    run(16);
    run(5);
    run(5);
    run(16);
    run(16);
    wrap_up();
  end

  // Watchdog sized well beyond the frame plan
  initial begin
    #200us;
    failures++;
    wrap_up();
  end
endmodule
